// >>> dv/stepper_power_stage.sv
`timescale 1ns/1ps
module stepper_power_stage (
   // Logic inputs of both bridges
   input  wire logic [1:0] phase_ab_i,
   input  wire logic [1:0] phase_cd_i,
   input  wire logic       first_bridge_inhibit_n_i,
   input  wire logic       second_bridge_inhibit_n_i,
   // Number of windings carrying current
   output logic [2:0]      wound_o
);
   logic [3:0] stage_on;

   // An inhibited bridge turns off all its transistors, so its lines are
   // ignored; each high line then feeds one single-ended winding stage.
   always_comb begin
      stage_on[3:2] = first_bridge_inhibit_n_i ? phase_ab_i : 2'h0;
      stage_on[1:0] = second_bridge_inhibit_n_i ? phase_cd_i : 2'h0;
      wound_o = {2'h0, stage_on[3]} + {2'h0, stage_on[2]}
              + {2'h0, stage_on[1]} + {2'h0, stage_on[0]};
   end
endmodule

// >>> dv/test_stepper_phase_sequencer.sv
`timescale 1ns/1ps
module test_stepper_phase_sequencer;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        step = 1'b0;
   logic        dir = 1'b1;
   logic        half = 1'b1;
   logic        enable = 1'b1;
   logic        run = 1'b1;
   logic [1:0]  ph1;
   logic [1:0]  ph2;
   logic        first_bridge_inhibit_n;
   logic        second_bridge_inhibit_n;
   logic        home_val;
   logic        home_oe_n;
   logic        home_wire;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic        hready;
   logic        hresp;
   logic [2:0]  wound;
   logic [2:0]  exp_cnt = 3'h0;
   logic [3:0]  exp_tab [8] = '{4'h5, 4'h1, 4'h9, 4'h8,
                                4'hA, 4'h2, 4'h6, 4'h4};
   int          n_errors = 0;
   int          n_compared = 0;
   int          cycles = 0;

   always #20 mclk = ~mclk;
   // Open-drain home line with a pull-up: released means high.
   assign home_wire = home_oe_n ? 1'b1 : home_val;

   stepper_phase_sequencer u_dut (
      .MCLK_I(mclk), .RST_N_I(rst_n), .STEP_I(step),
      .ROTATION_DIRECTION_I(dir), .HALF_FULL_I(half), .ENABLE_I(enable),
      .FIRST_PHASE_O(ph1), .SECOND_PHASE_O(ph2),
      .FIRST_BRIDGE_INHIBIT_N_O(first_bridge_inhibit_n), .SECOND_BRIDGE_INHIBIT_N_O(second_bridge_inhibit_n),
      .HOME_I(home_wire), .HOME_O(home_val), .HOME_OE_N_O(home_oe_n),
      .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
      .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp));

   stepper_power_stage u_stage (
      .phase_ab_i(ph1), .phase_cd_i(ph2),
      .first_bridge_inhibit_n_i(first_bridge_inhibit_n), .second_bridge_inhibit_n_i(second_bridge_inhibit_n),
      .wound_o(wound));

   task automatic print_verdict();
      $display("Compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Cut a hang short; the whole run needs about 150 cycles.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic check_drive(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: drive %b expected %b", $time, got, exp);
      end
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: word %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [3:0] exp_ph();
      return (enable && run) ? exp_tab[exp_cnt] : 4'h0;
   endfunction

   // Judge outputs away from the clock edge, once they have settled.
   task automatic check_state(input logic [3:0] ones);
      logic [3:0] e;
      @(negedge mclk);
      e = exp_ph();
      check_drive({ph1, ph2}, e);
      check_drive({2'h0, first_bridge_inhibit_n, second_bridge_inhibit_n}, {2'h0, |e[3:2], |e[1:0]});
      check_drive({1'b0, wound}, ones);
      check_drive({3'h0, home_wire}, {3'h0, exp_cnt == 3'h0});
   endtask

   task automatic do_step(input logic d, input logic h);
      @(posedge mclk);
      step <= 1'b1;
      dir <= d;
      half <= h;
      @(posedge mclk);
      step <= 1'b0;
      @(posedge mclk);
      if (h) begin
         exp_cnt = d ? exp_cnt + 3'h1 : exp_cnt - 3'h1;
      end else begin
         exp_cnt[2:1] = d ? exp_cnt[2:1] + 2'h1 : exp_cnt[2:1] - 2'h1;
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rdv);
      // Only the bench timeout ends a wait for the slave.
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do begin
         @(posedge mclk);
      end while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge mclk);
      end while (hready !== 1'b1);
      rdv = hrdata;
      check_word({31'h0, hresp}, 32'h0);
   endtask

   task automatic t_half(input logic d);
      for (int i = 0; i < 8; i++) begin
         do_step(d, 1'b1);
         check_state(exp_cnt[0] ? 4'h1 : 4'h2);
      end
   endtask

   task automatic t_full(input logic d, input logic [3:0] ones);
      for (int i = 0; i < 4; i++) begin
         do_step(d, 1'b0);
         check_state(ones);
      end
   endtask

   task automatic t_enable();
      @(posedge mclk);
      enable <= 1'b0;
      @(posedge mclk);
      check_state(4'h0);
      do_step(1'b1, 1'b1);
      check_state(4'h0);
      @(posedge mclk);
      enable <= 1'b1;
      @(posedge mclk);
      check_state(4'h1);
      do_step(1'b0, 1'b1);
      check_state(4'h2);
   endtask

   task automatic t_bus();
      logic [3:0] e;
      ahb(1'b0, 32'h0, 32'h0, rd);
      check_word(rd, 32'h1);
      e = exp_ph();
      ahb(1'b0, 32'h8, 32'h0, rd);
      check_word(rd, {19'h0, dir, half, 2'h3, |e[1:0], |e[3:2], e,
                      exp_cnt});
      ahb(1'b1, 32'h0, 32'h0, rd);
      run = 1'b0;
      // The pins follow the run bit one edge after the write lands.
      @(posedge mclk);
      check_state(4'h0);
      ahb(1'b1, 32'h0, 32'h1, rd);
      run = 1'b1;
      ahb(1'b1, 32'h4, 32'h1, rd);
      repeat (2) @(posedge mclk);
      exp_cnt = exp_cnt - 3'h1;
      check_state(4'h1);
      ahb(1'b0, 32'h4, 32'h0, rd);
      check_word(rd, 32'h0);
      ahb(1'b1, 32'h10, 32'hFFFF_FFFF, rd);
      ahb(1'b0, 32'h10, 32'h0, rd);
      check_word(rd, 32'h0);
      ahb(1'b0, 32'h0, 32'h0, rd);
      check_word(rd, 32'h1);
   endtask

   initial begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      check_state(4'h2);
      t_half(1'b1);
      t_half(1'b0);
      t_full(1'b1, 4'h2);
      t_full(1'b0, 4'h2);
      do_step(1'b1, 1'b1);
      t_full(1'b1, 4'h1);
      t_full(1'b0, 4'h1);
      do_step(1'b0, 1'b1);
      check_state(4'h2);
      t_enable();
      @(posedge mclk);
      dir <= 1'b0;
      t_bus();
      print_verdict();
   end
endmodule

// >>> verilog/stepper_ahb_regs.sv
`timescale 1ns/1ps
module stepper_ahb_regs (
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_n_i,
   // AHB-Lite slave
   input  wire logic                    hsel_i,
   input  wire logic [31:0]             haddr_i,
   input  wire logic [1:0]              htrans_i,
   input  wire logic                    hwrite_i,
   input  wire logic [31:0]             hwdata_i,
   input  wire logic                    hready_i,
   output logic [31:0]                  hrdata_o,
   output logic                         hreadyout_o,
   output logic                         hresp_o,
   // Block side
   input  wire stepper_pkg::status_s    status_i,
   output logic                         run_o,
   output logic                         step_o
);

   logic        wr_q;
   logic        wr_d;
   logic [31:0] addr_q;
   logic [31:0] addr_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        run_q;
   logic        run_d;
   logic        step_q;
   logic        step_d;
   logic        acc;

   // Zero wait states; read data is captured in the address phase so
   // that it stands for the whole data phase.
   always_comb begin
      acc     = hsel_i & htrans_i[stepper_pkg::NONSEQ_BIT] & hready_i;
      wr_d    = acc & hwrite_i;
      addr_d  = haddr_i;
      run_d   = run_q;
      step_d  = 1'b0;
      rdata_d = 32'h0000_0000;
      if (wr_q && addr_q == stepper_pkg::CTRL_OFS) begin
         run_d = hwdata_i[stepper_pkg::RUN_BIT];
      end
      if (wr_q && addr_q == stepper_pkg::STEP_OFS) begin
         step_d = hwdata_i[stepper_pkg::GO_BIT];
      end
      if (acc && !hwrite_i) begin
         if (haddr_i == stepper_pkg::CTRL_OFS) begin
            rdata_d[stepper_pkg::RUN_BIT] = run_q;
         end else if (haddr_i == stepper_pkg::STATUS_OFS) begin
            rdata_d[stepper_pkg::STATUS_W-1:0] = status_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_q    <= 1'b0;
         addr_q  <= 32'h0000_0000;
         rdata_q <= 32'h0000_0000;
         run_q   <= stepper_pkg::RUN_RST;
         step_q  <= 1'b0;
      end else begin
         wr_q    <= wr_d;
         addr_q  <= addr_d;
         rdata_q <= rdata_d;
         run_q   <= run_d;
         step_q  <= step_d;
      end
   end

   assign hrdata_o    = rdata_q;
   assign hreadyout_o = 1'b1;
   assign hresp_o     = stepper_pkg::RESP_OKAY;
   assign run_o       = run_q;
   assign step_o      = step_q;

endmodule

// >>> verilog/stepper_phase_decode.sv
`timescale 1ns/1ps
module stepper_phase_decode (
   // Sequencer state
   input  wire logic [stepper_pkg::CNT_W-1:0] cnt_i,
   input  wire logic                          en_i,
   // Decoded drive
   output stepper_pkg::phase_s                phase_o,
   output logic [1:0]                         inh_n_o
);

   // The same table serves bridges and single-ended stages alike.
   always_comb begin
      if (en_i) begin
         phase_o = stepper_pkg::MASTER_SEQ[cnt_i]; // RL10
         inh_n_o = {phase_o.c | phase_o.d, phase_o.a | phase_o.b}; // RL9
      end else begin
         phase_o = stepper_pkg::PHASES_OFF; // RL14
         inh_n_o = stepper_pkg::INH_N_OFF; // RL14
      end
   end

endmodule

// >>> verilog/stepper_phase_sequencer.sv
// Notes on behaviour
// RL1: Bipolar wave drive energises one winding at a time in the order A, C, B, D.
// RL2: In wave drive no state ever has more than one phase line high.
// RL3: Two-phase-on full step keeps both windings energised in every state.
// RL4: Half step alternates one-phase and two-phase states, eight per cycle.
// RL5: The opposite direction walks the same sequences in reverse order.
// RL6: A reluctance motor in wave drive sees its windings singly as A, C, B, D.
// RL7: A reluctance motor in two-phase-on sees pairs AC, CB, BD, DA in turn.
// RL8: A reluctance motor in half step runs the eight-state interleaved cycle.
// RL9: Each bridge gets two phase lines and one active-low inhibit line.
// RL10: Unipolar motors get the very same phase sequences as bipolar ones.
// RL11: A three-bit counter is decoded into an eight-state Gray sequence.
// RL12: Full step moves the counter by two, keeping its lowest bit as it was.
// RL13: Reset forces state 1 with phases 0101 and flags home.
// RL14: Enable low drives both inhibits and all four phase lines low (while reset is held the outputs stay 0101 with both inhibits high).
// RL15: Each rising step edge moves one state in the chosen direction.
// RL16: The half/full input is sampled at every step.
`timescale 1ns/1ps
module stepper_phase_sequencer (
   // Clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        RST_N_I,
   // Host control pins
   input  wire logic        STEP_I,
   input  wire logic        ROTATION_DIRECTION_I,
   input  wire logic        HALF_FULL_I,
   input  wire logic        ENABLE_I,
   // Power stage drive
   output logic [1:0]       FIRST_PHASE_O,
   output logic [1:0]       SECOND_PHASE_O,
   output logic             FIRST_BRIDGE_INHIBIT_N_O,
   output logic             SECOND_BRIDGE_INHIBIT_N_O,
   // Open-drain home pin
   input  wire logic        HOME_I,
   output logic             HOME_O,
   output logic             HOME_OE_N_O,
   // AHB-Lite slave
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic [31:0]      HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O
);

   localparam int W = stepper_pkg::CNT_W;

   logic [W-1:0]        cnt_q;
   logic [W-1:0]        cnt_d;
   logic                step_pin_q;
   logic                step_pin_d;
   logic                step_ev;
   logic                run;
   logic                sw_step;
   logic                en_d;
   logic                en_q;
   stepper_pkg::phase_s phase_d;
   stepper_pkg::phase_s phase_q;
   logic [1:0]          inh_n_d;
   logic [1:0]          inh_n_q;
   logic                home_d;
   logic                home_q;
   stepper_pkg::status_s status;

   // Only full words are ever transferred, so the size is not decoded.
   logic                unused_size;
   assign unused_size = ^HSIZE_I;

   stepper_ahb_regs u_regs (
      .clk_i       (MCLK_I),
      .rst_n_i     (RST_N_I),
      .hsel_i      (HSEL_I),
      .haddr_i     (HADDR_I),
      .htrans_i    (HTRANS_I),
      .hwrite_i    (HWRITE_I),
      .hwdata_i    (HWDATA_I),
      .hready_i    (HREADY_I),
      .hrdata_o    (HRDATA_O),
      .hreadyout_o (HREADYOUT_O),
      .hresp_o     (HRESP_O),
      .status_i    (status),
      .run_o       (run),
      .step_o      (sw_step)
   );

   // Step group: a pin edge or a software step moves the counter.
   always_comb begin
      step_pin_d = STEP_I;
      step_ev    = (STEP_I & ~step_pin_q) | sw_step; // RL15
      cnt_d      = cnt_q;
      if (step_ev) begin
         // RL5 RL11 RL12 RL16
         cnt_d = stepper_pkg::next_count(cnt_q, ROTATION_DIRECTION_I,
                                         HALF_FULL_I);
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cnt_q      <= stepper_pkg::HOME_CNT; // RL13
         step_pin_q <= 1'b0;
      end else begin
         cnt_q      <= cnt_d;
         step_pin_q <= step_pin_d;
      end
   end

   // Output group: decoded from the next count so that the pins follow
   // the counter in the same edge and still come straight from flops.
   always_comb begin
      en_d   = ENABLE_I & run; // RL14
      home_d = (cnt_d == stepper_pkg::HOME_CNT); // RL13
   end

   // RL1 RL6 RL7 RL8 RL10
   stepper_phase_decode u_decode (
      .cnt_i   (cnt_d),
      .en_i    (en_d),
      .phase_o (phase_d),
      .inh_n_o (inh_n_d)
   );

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         en_q    <= 1'b0;
         phase_q <= stepper_pkg::HOME_PHASES; // RL13
         inh_n_q <= stepper_pkg::INH_N_RST;
         home_q  <= 1'b1;
      end else begin
         en_q    <= en_d;
         phase_q <= phase_d;
         inh_n_q <= inh_n_d;
         home_q  <= home_d;
      end
   end

   // RL9
   assign FIRST_PHASE_O             = {phase_q.a, phase_q.b};
   assign SECOND_PHASE_O            = {phase_q.c, phase_q.d};
   assign FIRST_BRIDGE_INHIBIT_N_O  = inh_n_q[0];
   assign SECOND_BRIDGE_INHIBIT_N_O = inh_n_q[1];

   // The pin is released at home so an external sensor can pull it low;
   // reading it back gives the wired combination of both.
   assign HOME_O      = home_q; // RL13
   assign HOME_OE_N_O = home_q;

   always_comb begin
      status.rot_dir = ROTATION_DIRECTION_I;
      status.half    = HALF_FULL_I;
      status.sensor  = HOME_I;
      status.home    = home_q;
      status.inh_n   = inh_n_q;
      status.phases  = phase_q;
      status.cnt     = cnt_q;
   end

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_N_I);

   sequence s_held_on;
      en_q && ENABLE_I && run;
   endsequence

   sequence s_cw_full;
      step_ev && ROTATION_DIRECTION_I && !HALF_FULL_I;
   endsequence

   sequence s_cw_half;
      step_ev && ROTATION_DIRECTION_I && HALF_FULL_I;
   endsequence

   sequence s_ccw_full;
      step_ev && !ROTATION_DIRECTION_I && !HALF_FULL_I;
   endsequence

   sequence s_ccw_half;
      step_ev && !ROTATION_DIRECTION_I && HALF_FULL_I;
   endsequence

   property p_wave_order;
      s_held_on ##0 (phase_q == stepper_pkg::WAVE_A) ##0 s_cw_full
         |=> phase_q == stepper_pkg::WAVE_C;
   endproperty
   a_wave_order: assert property (p_wave_order) // RL1
      else $error("wave drive did not move from A to C");

   property p_wave_one;
      en_q && cnt_q[0] |-> $onehot(phase_q);
   endproperty
   a_wave_one: assert property (p_wave_one) // RL2
      else $error("single-phase state drives other than one line");

   property p_two_on;
      en_q && !cnt_q[0] |-> $countones(phase_q) == 2;
   endproperty
   a_two_on: assert property (p_two_on) // RL3
      else $error("two-phase state does not drive two lines");

   property p_half_alt;
      step_ev && HALF_FULL_I |=> cnt_q[0] != $past(cnt_q[0]);
   endproperty
   a_half_alt: assert property (p_half_alt) // RL4
      else $error("half step did not alternate state kind");

   property p_ccw_reverse;
      step_ev && !ROTATION_DIRECTION_I && HALF_FULL_I
         |=> cnt_q == W'($past(cnt_q) - 3'h1);
   endproperty
   a_ccw_reverse: assert property (p_ccw_reverse) // RL5
      else $error("reverse step did not go back one state");

   property p_pair_order;
      s_held_on ##0 (phase_q == stepper_pkg::PAIR_AC) ##0 s_cw_full
         |=> phase_q == stepper_pkg::PAIR_CB;
   endproperty
   a_pair_order: assert property (p_pair_order) // RL7
      else $error("pair AC was not followed by pair CB");

   property p_half_a_ac;
      s_held_on ##0 (phase_q == stepper_pkg::WAVE_A) ##0 s_cw_half
         |=> phase_q == stepper_pkg::PAIR_AC;
   endproperty
   a_half_a_ac: assert property (p_half_a_ac) // RL8
      else $error("half step from A did not reach AC");

   property p_inhibit;
      en_q |-> inh_n_q == {phase_q.c | phase_q.d, phase_q.a | phase_q.b};
   endproperty
   a_inhibit: assert property (p_inhibit) // RL9
      else $error("inhibit line does not follow its phase pair");

   property p_gray;
      s_held_on ##0 (step_ev && HALF_FULL_I)
         |=> $countones(phase_q ^ $past(phase_q)) == 1;
   endproperty
   a_gray: assert property (p_gray) // RL11
      else $error("half step changed more than one phase line");

   property p_full_skip;
      step_ev && !HALF_FULL_I |=> cnt_q[0] == $past(cnt_q[0])
         && cnt_q[2:1] != $past(cnt_q[2:1]);
   endproperty
   a_full_skip: assert property (p_full_skip) // RL12
      else $error("full step did not skip a master state");

   property p_home;
      (home_q == (cnt_q == stepper_pkg::HOME_CNT))
         && (home_q && en_q -> phase_q == stepper_pkg::HOME_PHASES);
   endproperty
   a_home: assert property (p_home) // RL13
      else $error("home flag or home phases wrong");

   property p_disable;
      !ENABLE_I |=> phase_q == stepper_pkg::PHASES_OFF
         && inh_n_q == stepper_pkg::INH_N_OFF;
   endproperty
   a_disable: assert property (p_disable) // RL14
      else $error("outputs not low one cycle after enable low");

   property p_cw_step;
      s_cw_half |=> cnt_q == W'($past(cnt_q) + 3'h1);
   endproperty
   a_cw_step: assert property (p_cw_step) // RL15
      else $error("forward step did not advance one state");

   property p_no_step_hold;
      !step_ev |=> cnt_q == $past(cnt_q);
   endproperty
   a_no_step_hold: assert property (p_no_step_hold) // RL16
      else $error("counter moved without a step");

   property p_wave_back;
      s_held_on ##0 (phase_q == stepper_pkg::WAVE_C) ##0 s_ccw_full
         |=> phase_q == stepper_pkg::WAVE_A;
   endproperty
   a_wave_back: assert property (p_wave_back) // RL5 RL6
      else $error("reverse wave drive did not move from C to A");

   property p_pair_back;
      s_held_on ##0 (phase_q == stepper_pkg::PAIR_CB) ##0 s_ccw_full
         |=> phase_q == stepper_pkg::PAIR_AC;
   endproperty
   a_pair_back: assert property (p_pair_back) // RL5 RL7
      else $error("reverse pair drive did not move from CB to AC");

   property p_half_back;
      s_held_on ##0 (phase_q == stepper_pkg::PAIR_AC) ##0 s_ccw_half
         |=> phase_q == stepper_pkg::WAVE_A;
   endproperty
   a_half_back: assert property (p_half_back) // RL5 RL8
      else $error("reverse half step from AC did not reach A");

   property p_half_c_cb;
      s_held_on ##0 (phase_q == stepper_pkg::WAVE_C) ##0 s_cw_half
         |=> phase_q == stepper_pkg::PAIR_CB;
   endproperty
   a_half_c_cb: assert property (p_half_c_cb) // RL8
      else $error("half step from C did not reach CB");

endmodule

// >>> verilog/stepper_pkg.sv
package stepper_pkg;

   // Sequencer counter and home position.
   localparam int               CNT_W    = 3;
   localparam logic [CNT_W-1:0] HOME_CNT = 3'h0;

   // Phase lines in the order A, B (first bridge), C, D (second bridge).
   typedef struct packed {
      logic a;
      logic b;
      logic c;
      logic d;
   } phase_s;

   localparam phase_s     PHASES_OFF  = 4'h0;
   localparam phase_s     HOME_PHASES = 4'h5;
   localparam phase_s     WAVE_A      = 4'h8;
   localparam phase_s     WAVE_C      = 4'h2;
   localparam phase_s     PAIR_AC     = 4'hA;
   localparam phase_s     PAIR_CB     = 4'h6;
   localparam logic [1:0] INH_N_RST   = 2'h3;
   localparam logic [1:0] INH_N_OFF   = 2'h0;

   // Master sequence, one entry per counter value; state 1 is entry 0.
   localparam phase_s MASTER_SEQ [8] = '{
      4'h5, 4'h1, 4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4 // RL2 RL3 RL4 RL11
   };

   // Register map, byte addresses.
   localparam logic [31:0] CTRL_OFS   = 32'h0000_0000;
   localparam logic [31:0] STEP_OFS   = 32'h0000_0004;
   localparam logic [31:0] STATUS_OFS = 32'h0000_0008;
   localparam int          RUN_BIT    = 0;
   localparam int          GO_BIT     = 0;
   localparam logic        RUN_RST    = 1'b1;
   localparam int          NONSEQ_BIT = 1;
   localparam logic        RESP_OKAY  = 1'b0;
   localparam int          STATUS_W   = 13;

   typedef struct packed {
      logic         rot_dir;
      logic         half;
      logic         sensor;
      logic         home;
      logic [1:0]   inh_n;
      phase_s       phases;
      logic [CNT_W-1:0] cnt;
   } status_s;

   // Next counter value; full step leaves the least significant bit alone.
   function automatic logic [CNT_W-1:0] next_count(
      input logic [CNT_W-1:0] c,
      input logic             cw,
      input logic             half
   );
      logic [CNT_W-1:0] n;
      n = c;
      if (half) begin
         n = cw ? c + 3'h1 : c - 3'h1;
      end else begin
         n[2:1] = cw ? c[2:1] + 2'h1 : c[2:1] - 2'h1;
      end
      return n;
   endfunction

endpackage
